// ---- pkg/ccsg_pkg.sv ----
// Shared constants and types of the clock select, gate and divide block
package ccsg_pkg;

    // ****************************************
    // Structure
    // ****************************************
    localparam int CCSG_NSRC = 4;
    localparam int CCSG_NSECT = 4;
    localparam int CCSG_CFG_W = 9;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [11:0] CCSG_ADDR_CTRL = 12'h000;
    localparam logic [11:0] CCSG_ADDR_CFG = 12'h004;
    localparam logic [11:0] CCSG_ADDR_STAT = 12'h008;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CCSG_CTRL_SEL_LSB = 0;
    localparam int CCSG_CTRL_ENA_BIT = 2;
    localparam int CCSG_STAT_ACT_LSB = 0;
    localparam int CCSG_STAT_BUSY_BIT = 2;
    localparam int CCSG_STAT_EN_BIT = 3;
    localparam int CCSG_STAT_SMP_LSB = 4;

    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [1:0] {
        CCSG_SRC_ONE = 2'h0,
        CCSG_SRC_TWO = 2'h1,
        CCSG_SRC_FOUR = 2'h2
    } ccsg_nsrc_t;

    typedef enum logic [1:0] {
        CCSG_DIV_1X = 2'h0,
        CCSG_DIV_12X = 2'h1,
        CCSG_DIV_124X = 2'h2
    } ccsg_divp_t;

    typedef enum logic [2:0] {
        CCSG_RUN = 3'b001,
        CCSG_STOP_OLD = 3'b010,
        CCSG_START_NEW = 3'b100
    } ccsg_sw_state_t;

    // Configuration word, bit 8 down to bit 0
    typedef struct packed {
        ccsg_divp_t divp;
        logic div_on;
        logic sector;
        logic latch;
        logic gate_on;
        logic glitch_free;
        ccsg_nsrc_t nsrc;
    } ccsg_cfg_t;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [1:0] CCSG_SEL_RST = 2'h0;
    localparam logic CCSG_ENA_RST = 1'b0;
    localparam ccsg_cfg_t CCSG_CFG_RST = '{divp: CCSG_DIV_124X, div_on: 1'b0, sector: 1'b0, latch: 1'b1,
                                           gate_on: 1'b0, glitch_free: 1'b1, nsrc: CCSG_SRC_FOUR};

endpackage

// ---- pkg/ccsg_clk_if.sv ----
// Carrier between the top and its synchroniser and gate/divide stages
`timescale 1ns/10ps
interface ccsg_clk_if;
    import ccsg_pkg::*;
    logic [3:0] pins;
    logic [3:0] src;
    logic mux_clk;
    logic ena;
    ccsg_cfg_t cfg;
    logic net_clk;
    logic [3:0] sector_clk;
    logic pass;
    logic half;
    logic quarter;
    logic en_eff;
    modport syn (input pins, output src);
    modport gd (input mux_clk, ena, cfg, output net_clk, sector_clk, pass, half, quarter, en_eff);
    modport top (output pins, mux_clk, ena, cfg, input src, net_clk, sector_clk, pass, half, quarter, en_eff);
endinterface

// ---- logic/ccsg_sync.sv ----
// Two-stage synchroniser for the four source clock pins
`timescale 1ns/10ps
module ccsg_sync (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Pins in, sampled levels out
    ccsg_clk_if.syn io
);
    import ccsg_pkg::*;

    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] sync;
    } ccsg_sync_st_t;

    ccsg_sync_st_t sync_reg;
    ccsg_sync_st_t sync_next;

    // First stage feeds only the second
    always_comb begin
        sync_next.meta = io.pins;
        sync_next.sync = sync_reg.meta;
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign io.src = sync_reg.sync;

endmodule // ccsg_sync

// ---- logic/ccsg_gate_div.sv ----
// Enable gate, sector gates and pass/half/quarter divider
`timescale 1ns/10ps
module ccsg_gate_div (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Selected clock in, network clocks out
    ccsg_clk_if.gd io
);
    import ccsg_pkg::*;

    typedef struct packed {
        logic en_lat;
        logic clk_prev;
        logic net;
        logic [3:0] sect;
        logic pass;
        logic half;
        logic quarter;
    } ccsg_gd_st_t;

    ccsg_gd_st_t gd_reg;
    ccsg_gd_st_t gd_next;
    logic div_act;
    logic en_eff;
    logic gclk;
    logic root;
    logic rise;

    // ****************************************
    // Gate and divider
    // ****************************************
    always_comb begin
        gd_next = gd_reg;
        div_act = io.cfg.div_on & ~io.cfg.gate_on;
        gd_next.en_lat = io.mux_clk ? gd_reg.en_lat : io.ena;
        en_eff = io.cfg.latch ? gd_reg.en_lat : io.ena;
        gclk = io.mux_clk & en_eff;
        root = (io.cfg.gate_on & ~io.cfg.sector) ? gclk : io.mux_clk;
        for (int i = 0; i < CCSG_NSECT; i++) begin
            gd_next.sect[i] = (io.cfg.gate_on & io.cfg.sector) ? gclk : root;
        end
        gd_next.net = div_act ? 1'b0 : root;
        rise = io.mux_clk & ~gd_reg.clk_prev;
        gd_next.clk_prev = io.mux_clk;
        gd_next.pass = div_act & io.mux_clk;
        gd_next.half = (div_act && io.cfg.divp != CCSG_DIV_1X) ? (gd_reg.half ^ rise) : 1'b0;
        gd_next.quarter = (div_act && io.cfg.divp == CCSG_DIV_124X) ?
                          (gd_reg.quarter ^ (gd_next.half & ~gd_reg.half)) : 1'b0;
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            gd_reg <= '0;
        end else begin
            gd_reg <= gd_next;
        end
    end

    assign io.net_clk = gd_reg.net;
    assign io.sector_clk = gd_reg.sect;
    assign io.pass = gd_reg.pass;
    assign io.half = gd_reg.half;
    assign io.quarter = gd_reg.quarter;
    assign io.en_eff = en_eff;

    // ****************************************
    // Checks
    // ****************************************
    AST_GATE_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        io.cfg.gate_on && !io.cfg.sector && !io.cfg.latch && !io.ena |=> !gd_reg.net)
        else $error("gated output not held off");
    AST_LATCH_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        io.mux_clk |=> gd_reg.en_lat == $past(gd_reg.en_lat))
        else $error("enable latch changed in high phase");
    AST_DIV_BLOCK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        io.cfg.gate_on |=> !gd_reg.pass && !gd_reg.half && !gd_reg.quarter)
        else $error("divider active while gating");
    AST_NET_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        div_act |=> !gd_reg.net)
        else $error("network output active while dividing");
    AST_HALF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        div_act && $past(div_act) && $past(div_act, 2) && io.cfg.divp != CCSG_DIV_1X &&
        $stable(io.cfg.divp) && $rose(gd_reg.pass)
        |-> gd_reg.half != $past(gd_reg.half))
        else $error("half rate did not toggle");
    AST_ONLY_1X: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        io.cfg.divp == CCSG_DIV_1X |=> !gd_reg.half && !gd_reg.quarter)
        else $error("absent divided output active");
    CVR_QUARTER: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(gd_reg.quarter));
    CVR_GATED: cover property (@(posedge i_clk) disable iff (!i_rst_n) io.cfg.gate_on && io.mux_clk && !gclk);

endmodule // ccsg_gate_div

// ---- logic/ccsg_top.sv ----
// Clock select, gate and divide block with APB control
//
// Behaviour
// - Configured for one, two or four sources; unused select bits are ignored.
// - Select 00, 01, 10, 11 picks source 0, 1, 2, 3.
// - Select is two bits wide and may change at run time.
// - Select resets to 00 and is sampled on source 0 rising edges.
// - With gating configured, divided outputs are unavailable.
// - Enable is active high; low holds the gated output off.
// - Enable is either captured by a negative latch or applied directly.
// - Gate sits at the root or at each sector.
// - Without divider, one network output carries the selected or gated clock.
// - With divider, pass-through, half-rate and quarter-rate outputs are driven.
// - Divided outputs configurable as 1x, 1x+2x or 1x+2x+4x.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
module ccsg_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Source clock pins
    input wire logic i_source_clock_0,
    input wire logic i_source_clock_1,
    input wire logic i_source_clock_2,
    input wire logic i_source_clock_3,
    // Network clocks
    output logic o_net_clk,
    output logic [3:0] o_sector_clk,
    output logic o_pass_through_out,
    output logic o_half_rate_out,
    output logic o_quarter_rate_out
);
    import ccsg_pkg::*;

    typedef struct packed {
        logic [1:0] ctrl_sel;
        logic ctrl_ena;
        ccsg_cfg_t cfg;
        logic [31:0] prdata;
        ccsg_sw_state_t state;
        logic [1:0] cur;
        logic [1:0] tgt;
        logic out;
        logic [1:0] sel_smp;
        logic s0_prev;
    } ccsg_top_st_t;

    ccsg_top_st_t top_reg;
    ccsg_top_st_t top_next;
    ccsg_clk_if io ();
    logic setup;
    logic access;
    logic hit;
    logic [1:0] sel_req;
    logic [3:0] src;

    // ****************************************
    // Stages
    // ****************************************
    ccsg_sync u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .io(io.syn)
    );

    ccsg_gate_div u_gate_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .io(io.gd)
    );

    // Pins go through the synchroniser before any logic
    assign io.pins = {i_source_clock_3, i_source_clock_2, i_source_clock_1, i_source_clock_0};
    assign src = io.src;
    assign io.mux_clk = top_reg.out;
    assign io.ena = top_reg.ctrl_ena;
    assign io.cfg = top_reg.cfg;

    // ****************************************
    // Bus decode
    // ****************************************
    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable;
    assign hit = (i_paddr == CCSG_ADDR_CTRL) || (i_paddr == CCSG_ADDR_CFG) || (i_paddr == CCSG_ADDR_STAT);

    always_comb begin
        unique case (top_reg.cfg.nsrc)
            CCSG_SRC_ONE: begin
                sel_req = 2'h0;
            end
            CCSG_SRC_TWO: begin
                sel_req = {1'b0, top_reg.ctrl_sel[0]};
            end
            default: begin
                sel_req = top_reg.ctrl_sel;
            end
        endcase
    end

    // ****************************************
    // Registers and switch sequencer
    // ****************************************
    always_comb begin
        top_next = top_reg;
        // Read data is caught in setup so the access phase needs no wait
        if (setup && !i_pwrite) begin
            top_next.prdata = 32'h0000_0000;
            if (i_paddr == CCSG_ADDR_CTRL) begin
                top_next.prdata[CCSG_CTRL_SEL_LSB +: 2] = top_reg.ctrl_sel;
                top_next.prdata[CCSG_CTRL_ENA_BIT] = top_reg.ctrl_ena;
            end else if (i_paddr == CCSG_ADDR_CFG) begin
                top_next.prdata[CCSG_CFG_W-1:0] = top_reg.cfg;
            end else if (i_paddr == CCSG_ADDR_STAT) begin
                top_next.prdata[CCSG_STAT_ACT_LSB +: 2] = top_reg.cur;
                top_next.prdata[CCSG_STAT_BUSY_BIT] = (top_reg.state != CCSG_RUN);
                top_next.prdata[CCSG_STAT_EN_BIT] = io.en_eff;
                top_next.prdata[CCSG_STAT_SMP_LSB +: 2] = top_reg.sel_smp;
            end
        end
        if (access && i_pwrite && i_paddr == CCSG_ADDR_CTRL) begin
            top_next.ctrl_sel = i_pwdata[CCSG_CTRL_SEL_LSB +: 2];
            top_next.ctrl_ena = i_pwdata[CCSG_CTRL_ENA_BIT];
        end
        if (access && i_pwrite && i_paddr == CCSG_ADDR_CFG) begin
            top_next.cfg = ccsg_cfg_t'(i_pwdata[CCSG_CFG_W-1:0]);
        end
        // select sampled on source 0 rise
        top_next.s0_prev = src[0];
        if (src[0] && !top_reg.s0_prev) begin
            top_next.sel_smp = sel_req;
        end
        unique case (top_reg.state)
            CCSG_RUN: begin
                top_next.out = src[top_reg.cur];
                if (top_reg.sel_smp != top_reg.cur) begin
                    if (top_reg.cfg.glitch_free) begin
                        top_next.tgt = top_reg.sel_smp;
                        top_next.state = CCSG_STOP_OLD;
                    end else begin
                        // Plain mux: may cut a pulse short, by choice of config
                        top_next.cur = top_reg.sel_smp;
                        top_next.out = src[top_reg.sel_smp];
                    end
                end
            end
            // park old clock in low phase
            CCSG_STOP_OLD: begin
                // stalls here while old clock stands high
                top_next.out = src[top_reg.cur];
                if (!src[top_reg.cur]) begin
                    top_next.out = 1'b0;
                    top_next.state = CCSG_START_NEW;
                end
            end
            // take new clock in low phase
            CCSG_START_NEW: begin
                top_next.out = 1'b0;
                if (!src[top_reg.tgt]) begin
                    top_next.cur = top_reg.tgt;
                    top_next.state = CCSG_RUN;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            top_reg.ctrl_sel <= CCSG_SEL_RST;
            top_reg.ctrl_ena <= CCSG_ENA_RST;
            top_reg.cfg <= CCSG_CFG_RST;
            top_reg.prdata <= 32'h0000_0000;
            top_reg.state <= CCSG_RUN;
            top_reg.cur <= CCSG_SEL_RST;
            top_reg.tgt <= CCSG_SEL_RST;
            top_reg.out <= 1'b0;
            top_reg.sel_smp <= CCSG_SEL_RST;
            top_reg.s0_prev <= 1'b0;
        end else begin
            top_reg <= top_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_prdata = top_reg.prdata;
    assign o_pready = access;
    assign o_pslverr = access & ~hit;
    assign o_net_clk = io.net_clk;
    assign o_sector_clk = io.sector_clk;
    assign o_pass_through_out = io.pass;
    assign o_half_rate_out = io.half;
    assign o_quarter_rate_out = io.quarter;

    // ****************************************
    // Checks
    // ****************************************
    default clocking ccsg_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    AST_SEL_RESET: assert property ($rose(i_rst_n) |-> top_reg.ctrl_sel == 2'h0 && top_reg.sel_smp == 2'h0)
        else $error("select not 00 after reset");
    AST_SEL_WRITE: assert property (
        access && i_pwrite && i_paddr == CCSG_ADDR_CTRL |=> top_reg.ctrl_sel == $past(i_pwdata[1:0]))
        else $error("select write lost");
    AST_SEL_MASK: assert property (
        top_reg.cfg.nsrc == CCSG_SRC_ONE && src[0] && !top_reg.s0_prev |=> top_reg.sel_smp == 2'h0)
        else $error("absent source selected");
    AST_SEL_SMP: assert property (!(src[0] && !top_reg.s0_prev) |=> $stable(top_reg.sel_smp))
        else $error("select sampled without source 0 edge");
    AST_MAP: assert property (
        top_reg.state == CCSG_RUN && $past(top_reg.state) == CCSG_RUN && $stable(top_reg.cur)
        |-> top_reg.out == $past(src[top_reg.cur]))
        else $error("output does not follow selected source");
    AST_GF_LOW: assert property (top_reg.state == CCSG_START_NEW |-> !top_reg.out)
        else $error("output high during handover");
    AST_NO_CUT: assert property (
        $changed(top_reg.cur) && $past(top_reg.cfg.glitch_free) |-> $past(top_reg.state) == CCSG_START_NEW)
        else $error("glitch-free switch skipped handover");
    AST_STOP_WAIT: assert property (
        top_reg.state == CCSG_STOP_OLD && src[top_reg.cur] |=> top_reg.state == CCSG_STOP_OLD)
        else $error("left old clock while high");
    AST_ERR: assert property (access && !hit |-> o_pslverr && o_pready)
        else $error("unmapped access not flagged");
    CVR_SWITCH: cover property (top_reg.state == CCSG_START_NEW ##1 top_reg.state == CCSG_RUN);
    CVR_READ: cover property (access && !i_pwrite && i_paddr == CCSG_ADDR_STAT);
    CVR_SRC3: cover property (top_reg.cur == 2'h3 && top_reg.out);

endmodule // ccsg_top

// ---- bench/ccsg_src_model.sv ----
// Behavioural source clocks standing on the far side of the block
`timescale 1ns/10ps
module ccsg_src_model (
    // Source clocks towards the block
    output logic [3:0] o_src
);
    // ****************************************
    // Free-running sources
    // ****************************************
    logic [3:0] tgl;

    // Half periods 40, 50, 60, 70 ns; edges stay off the sampling grid
    for (genvar k = 0; k < 4; k++) begin : g_src
        initial begin
            tgl[k] = 1'b0;
            #2;
            forever begin
                #(40 + 10 * k) tgl[k] = ~tgl[k];
            end
        end
    end

    // Straight to the pins
    assign o_src = tgl;
endmodule // ccsg_src_model

// ---- bench/test_clock_select_gate_divide.sv ----
// Self-checking bench for the clock select, gate and divide block
`timescale 1ns/10ps
module test_clock_select_gate_divide;
    import ccsg_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, d;
    logic o_pready, o_pslverr, o_net_clk, o_pass_through_out, o_half_rate_out, o_quarter_rate_out;
    logic [3:0] o_sector_clk, src;
    logic [4:0] obs;
    logic e, mon_on;
    ccsg_cfg_t cfg;
    int fails, comparisons, hi_run;

    // Observed clocks: 0 net, 1 pass, 2 half, 3 quarter, 4 any sector
    assign obs = {|o_sector_clk, o_quarter_rate_out, o_half_rate_out, o_pass_through_out, o_net_clk};

    ccsg_src_model src_u (.o_src(src));

    ccsg_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_source_clock_0(src[0]), .i_source_clock_1(src[1]),
        .i_source_clock_2(src[2]), .i_source_clock_3(src[3]), .o_net_clk(o_net_clk),
        .o_sector_clk(o_sector_clk), .o_pass_through_out(o_pass_through_out),
        .o_half_rate_out(o_half_rate_out), .o_quarter_rate_out(o_quarter_rate_out));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v, output logic [31:0] r,
                       output logic er);
        int n;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= v;
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        r = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v, d, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        apb(1'b0, a, 32'h0, v, e);
    endtask

    // Rise-to-rise period in clock cycles, 0 when it never toggles
    task automatic measure(input int which, output int per);
        logic prev, cur;
        int n, edges;
        prev = 1'b1;
        n = 0;
        edges = 0;
        per = 0;
        while (edges < 2 && n < 200) begin
            @(posedge i_clk);
            #1;
            cur = obs[which];
            n++;
            if (edges == 1) per++;
            if (cur === 1'b1 && prev === 1'b0) edges++;
            prev = cur;
        end
        if (edges < 2) per = 0;
    endtask

    // High samples over a span, after the four-edge pipeline and a half period settle
    task automatic count_high(input int which, input int n, output int h);
        h = 0;
        repeat (10) @(posedge i_clk);
        repeat (n) begin
            @(posedge i_clk);
            #1;
            if (obs[which] !== 1'b0) h++;
        end
    endtask

    task automatic wait_switch(input logic [1:0] k);
        int n;
        n = 0;
        do begin
            rd(CCSG_ADDR_STAT, d);
            n++;
        end while ((d[1:0] !== k || d[2] !== 1'b0) && n < 60);
        check(d[2:0], {1'b0, k});
    endtask

    // no truncated high phase while watched
    // Falling edge keeps the sample clear of the output update
    always @(negedge i_clk) begin
        if (o_net_clk === 1'b1) begin
            hi_run <= hi_run + 1;
        end else begin
            if (mon_on && hi_run != 0) check(hi_run >= 4, 1'b1);
            hi_run <= 0;
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd(CCSG_ADDR_CTRL, d);
        check(d, 32'h0);
        rd(CCSG_ADDR_CFG, d);
        check(d, {23'h0, CCSG_CFG_RST});
    endtask

    // Unmapped place refused, status not writable
    task automatic t_unmapped;
        apb(1'b1, 12'h00c, 32'h3, d, e);
        check(e, 1'b1);
        apb(1'b0, 12'h00c, 32'h0, d, e);
        check(d, 32'h0);
        check(e, 1'b1);
        apb(1'b1, CCSG_ADDR_STAT, 32'hff, d, e);
        check(e, 1'b0);
        wait_switch(2'h0);
    endtask

    task automatic t_select;
        int per;
        logic [1:0] k;
        for (int g = 1; g >= 0; g--) begin
            cfg = CCSG_CFG_RST;
            cfg.glitch_free = g[0];
            wr(CCSG_ADDR_CFG, {23'h0, cfg});
            mon_on = g[0];
            for (int i = 0; i < 4; i++) begin
                k = g[0] ? 2'(i) : 2'(3 - i);
                wr(CCSG_ADDR_CTRL, {30'h0, k});
                wait_switch(k);
                measure(0, per);
                check(per, 2 * (4 + k));
            end
            mon_on = 1'b0;
        end
    endtask

    task automatic t_count;
        cfg = CCSG_CFG_RST;
        cfg.nsrc = CCSG_SRC_ONE;
        wr(CCSG_ADDR_CFG, {23'h0, cfg});
        wr(CCSG_ADDR_CTRL, 32'h3);
        // Let source 0 sample the select first, else a wrong switch goes unseen
        repeat (24) @(posedge i_clk);
        wait_switch(2'h0);
        check(d[5:4], 2'h0);
        cfg.nsrc = CCSG_SRC_TWO;
        wr(CCSG_ADDR_CFG, {23'h0, cfg});
        wait_switch(2'h1);
        check(d[5:4], 2'h1);
        wr(CCSG_ADDR_CTRL, 32'h2);
        wait_switch(2'h0);
        check(d[5:4], 2'h0);
        wr(CCSG_ADDR_CFG, {23'h0, CCSG_CFG_RST});
    endtask

    task automatic t_gate;
        int per, h;
        for (int l = 1; l >= 0; l--) begin
            cfg = CCSG_CFG_RST;
            cfg.gate_on = 1'b1;
            cfg.div_on = 1'b1;
            cfg.latch = l[0];
            wr(CCSG_ADDR_CTRL, 32'h0);
            wr(CCSG_ADDR_CFG, {23'h0, cfg});
            count_high(0, 40, h);
            check(h, 0);
            count_high(4, 40, h);
            check(h, 0);
            mon_on = l[0];
            // Enable flips at odd moments; latched mode must keep whole pulses
            for (int i = 0; i < 6; i++) begin
                wr(CCSG_ADDR_CTRL, (i % 2) ? 32'h4 : 32'h0);
            end
            measure(0, per);
            check(per, 8);
            rd(CCSG_ADDR_STAT, d);
            check(d[3], 1'b1);
            count_high(1, 40, h);
            check(h, 0);
            mon_on = 1'b0;
        end
        // Sector gating leaves the network clock free
        cfg.sector = 1'b1;
        cfg.latch = 1'b1;
        wr(CCSG_ADDR_CFG, {23'h0, cfg});
        wr(CCSG_ADDR_CTRL, 32'h0);
        measure(0, per);
        check(per, 8);
        count_high(4, 40, h);
        check(h, 0);
    endtask

    task automatic t_divide;
        int per, h;
        for (int p = 0; p < 3; p++) begin
            cfg = CCSG_CFG_RST;
            cfg.div_on = 1'b1;
            cfg.divp = ccsg_divp_t'(p[1:0]);
            wr(CCSG_ADDR_CFG, {23'h0, cfg});
            measure(1, per);
            check(per, 8);
            measure(2, per);
            check(per, (p > 0) ? 16 : 0);
            measure(3, per);
            check(per, (p > 1) ? 32 : 0);
            count_high(0, 40, h);
            check(h, 0);
        end
    endtask

    // ****************************************
    // Clock, watchdog and main sequence
    // ****************************************
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Whole run is a few thousand cycles; this span is ample
    initial begin
        repeat (30000) @(posedge i_clk);
        fails++;
        final_report();
    end

    initial begin
        i_rst_n = 1'b0;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 12'h0;
        i_pwdata = 32'h0;
        mon_on = 1'b0;
        fails = 0;
        comparisons = 0;
        hi_run = 0;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_unmapped();
        t_select();
        t_count();
        t_gate();
        t_divide();
        final_report();
    end
endmodule // test_clock_select_gate_divide
